// ===== src/core_flags_regs.vh
`ifndef CORE_FLAGS_REGS_VH
`define CORE_FLAGS_REGS_VH

// full 8-bit data-memory addresses (bank bit on top)
`define FLAGS_ADDR_B0    8'h03
`define FLAGS_ADDR_B1    8'h83
`define OPTION_ADDR      8'h81
`define IRQCTL_ADDR_B0   8'h0B
`define IRQCTL_ADDR_B1   8'h8B

// flags/bank register fields
`define FL_RSV_HI        7
`define FL_RSV_B         6
`define FL_BANK          5
`define FL_WDT_EXP       4
`define FL_SLEEP         3
`define FL_ZERO          2
`define FL_DCARRY        1
`define FL_CARRY         0

// timer option register fields
`define OPT_PULLUP_DIS   7
`define OPT_EXT_EDGE     6
`define OPT_SRC_SEL      5
`define OPT_EDGE_SEL     4
`define OPT_PS_OWNER     3
`define OPT_RATE_HI      2
`define OPT_RATE_LO      0

// interrupt control register fields
`define IC_GIE           7
`define IC_PERIPHERAL_IRQ_GATE          6
`define IC_TMR_IE        5
`define IC_EXT_IE        4
`define IC_CHG_IE        3
`define IC_TMR_IF        2
`define IC_EXT_IF        1
`define IC_CHG_IF        0

// reset values
`define OPTION_RESET     8'hFF
`define IRQCTL_RESET     8'h00
`define FLAGS_HI_RESET   3'h0
`define FLAGS_LO_RESET   3'h0

// alu operation classes
`define ALU_ADD          3'h0
`define ALU_SUB          3'h1
`define ALU_LOGIC        3'h2
`define ALU_ROTL         3'h3
`define ALU_ROTR         3'h4

`endif

// ===== src/core_flags_option_irq_regs.v
`timescale 1ns/100ps
`default_nettype none
`include "core_flags_regs.vh"

module core_flags_option_irq_regs
(
  input  wire       clk,
  input  wire       reset_n,
  input  wire       ce,
  input  wire       wr_en,
  input  wire [6:0] wr_file_addr,
  input  wire [7:0] wr_data,
  input  wire       rd_en,
  input  wire [6:0] rd_file_addr,
  output reg  [7:0] rd_data,
  output reg        rd_hit,
  input  wire       alu_valid,
  input  wire [2:0] alu_op,
  input  wire [7:0] operand_a,
  input  wire [7:0] operand_b,
  input  wire       watchdog_clear_instr,
  input  wire       sleep_instr,
  input  wire       wdt_timeout,
  input  wire       instr_clk_tick,
  input  wire       wdt_base_tick,
  input  wire       timer_rollover,
  input  wire       periph_irq_pending,
  input  wire [5:0] per_pin_change_enable,
  input  wire [5:0] port_latch,
  input  wire [5:0] gpio_pins,
  input  wire       ext_irq_pin,
  input  wire       timer_clock_pin,
  output wire       bank_select_bit,
  output wire       carry_flag,
  output reg  [5:0] pullup_en,
  output reg        timer_inc,
  output reg        wdt_tick,
  output wire       irq_request
);

  localparam [1:0] SEL_NONE   = 2'h0;
  localparam [1:0] SEL_FLAGS  = 2'h1;
  localparam [1:0] SEL_OPTION = 2'h2;
  localparam [1:0] SEL_IRQCTL = 2'h3;

  reg  [2:0] bank_bits;      // reserved hi, reserved b, bank select
  reg        wdt_exp_flag;
  reg        sleep_flag;
  reg  [2:0] alu_flags;      // zero, digit carry, carry
  reg  [7:0] option_q;
  reg  [7:0] irqctl_q;
  reg  [7:0] presc_cnt;

  // register decode, shared by reads and writes
  function [1:0] decode;
    input       bank;
    input [6:0] file_addr;
    reg   [7:0] full;
    begin
      full = {bank, file_addr};
      if (full == `FLAGS_ADDR_B0 || full == `FLAGS_ADDR_B1)
        decode = SEL_FLAGS;
      else if (full == `OPTION_ADDR)
        decode = SEL_OPTION;
      else if (full == `IRQCTL_ADDR_B0 || full == `IRQCTL_ADDR_B1)
        decode = SEL_IRQCTL;
      else
        decode = SEL_NONE;
    end
  endfunction

  // mask of n low ones, n in 1..8
  function [7:0] low_mask;
    input [3:0] n;
    begin
      low_mask = 8'hFF >> (4'h8 - n);
    end
  endfunction

  wire [1:0] wr_sel = decode(bank_bits[0], wr_file_addr);
  wire [1:0] rd_sel = decode(bank_bits[0], rd_file_addr);
  wire       wr_flags  = wr_en && (wr_sel == SEL_FLAGS);
  wire       wr_option = wr_en && (wr_sel == SEL_OPTION);
  wire       wr_irqctl = wr_en && (wr_sel == SEL_IRQCTL);

  assign bank_select_bit = bank_bits[0];
  assign carry_flag      = alu_flags[0];

  // pin synchronisers: three stages, change accepted when 2nd and 3rd agree
  // bit order: 7 timer clock pin, 6 external irq pin, 5..0 port pins
  wire [7:0] pin_raw = {timer_clock_pin, ext_irq_pin, gpio_pins};
  wire [7:0] pin_level;
  wire [7:0] pin_prev;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : g_pin_sync
      reg s1;
      reg s2;
      reg s3;
      reg lvl;
      reg lvl_d;
      // s1 feeds s2 only; filtered level updates on agreement
      always @(posedge clk or negedge reset_n)
      begin
        if (!reset_n)
        begin
          s1    <= 1'b0;
          s2    <= 1'b0;
          s3    <= 1'b0;
          lvl   <= 1'b0;
          lvl_d <= 1'b0;
        end
        else if (ce)
        begin
          s1    <= pin_raw[gi];
          s2    <= s1;
          s3    <= s2;
          if (s2 == s3)
            lvl <= s3;
          lvl_d <= lvl;
        end
      end
      assign pin_level[gi] = lvl;
      assign pin_prev[gi]  = lvl_d;
    end
  endgenerate

  wire [7:0] pin_rise = pin_level & ~pin_prev;
  wire [7:0] pin_fall = ~pin_level & pin_prev;

  // first cycles after reset would see 0 -> pin level as an edge;
  // held off until the filtered levels have settled once
  reg  [2:0] settle;
  wire       settled = (settle == 3'h7);

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      settle <= 3'h0;
    else if (ce && !settled)
      settle <= settle + 3'h1;
  end

  // external pin edge per polarity bit
  wire ext_edge = settled && (option_q[`OPT_EXT_EDGE] ? pin_rise[6]
                                                     : pin_fall[6]);
  wire pin_change = settled && (|(pin_rise[5:0] | pin_fall[5:0]));

  // timer source tick: pin edge or instruction clock
  wire pin_tick = option_q[`OPT_EDGE_SEL] ? pin_fall[7]
                                          : pin_rise[7];
  wire tmr_src  = option_q[`OPT_SRC_SEL] ? (settled && pin_tick)
                                         : instr_clk_tick;

  // alu flag computation
  wire [8:0] add_sum = {1'b0, operand_a} + {1'b0, operand_b};
  wire [4:0] add_nib = {1'b0, operand_a[3:0]} + {1'b0, operand_b[3:0]};
  // subtract as a plus two's complement of b, carry is inverted borrow
  wire [8:0] sub_sum = {1'b0, operand_a} + {1'b0, ~operand_b} + 9'h001;
  wire [4:0] sub_nib = {1'b0, operand_a[3:0]} + {1'b0, ~operand_b[3:0]}
                       + 5'h01;

  reg  [2:0] op_flags;       // zero, digit carry, carry values
  reg  [2:0] op_mask;        // which of them the op affects

  // per-op flag values and affected-bit mask
  always @*
  begin
    op_flags = 3'h0;
    op_mask  = 3'h0;
    if (alu_valid)
    begin
      case (alu_op)
        `ALU_ADD:
        begin
          op_flags = {add_sum[7:0] == 8'h00, add_nib[4], add_sum[8]};
          op_mask  = 3'h7;
        end
        `ALU_SUB:
        begin
          op_flags = {sub_sum[7:0] == 8'h00, sub_nib[4], sub_sum[8]};
          op_mask  = 3'h7;
        end
        `ALU_LOGIC:
        begin
          op_flags = {operand_a == 8'h00, 2'h0};
          op_mask  = 3'h4;
        end
        `ALU_ROTL:
        begin
          op_flags = {2'h0, operand_a[7]};
          op_mask  = 3'h1;
        end
        `ALU_ROTR:
        begin
          op_flags = {2'h0, operand_a[0]};
          op_mask  = 3'h1;
        end
        default:
        begin
          op_flags = 3'h0;
          op_mask  = 3'h0;
        end
      endcase
    end
  end

  // flags/bank register; reserved bits stored as written, software's duty
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bank_bits    <= `FLAGS_HI_RESET;
      wdt_exp_flag <= 1'b1;
      sleep_flag   <= 1'b1;
      alu_flags    <= `FLAGS_LO_RESET;
    end
    else if (ce)
    begin
      if (wr_flags)
        bank_bits <= wr_data[`FL_RSV_HI:`FL_BANK];
      // any flag-affecting op locks all three bits against the write
      if (wr_flags && op_mask == 3'h0)
        alu_flags <= wr_data[`FL_ZERO:`FL_CARRY];
      else
        alu_flags <= (op_flags & op_mask)
                     | (alu_flags & ~op_mask);
      // no write path to these two bits at all
      if (wdt_timeout)
        wdt_exp_flag <= 1'b0;
      else if (watchdog_clear_instr || sleep_instr)
        wdt_exp_flag <= 1'b1;
      if (sleep_instr)
        sleep_flag <= 1'b0;
      else if (watchdog_clear_instr)
        sleep_flag <= 1'b1;
    end
  end

  // option register, fully writable
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      option_q <= `OPTION_RESET;
    else if (ce && wr_option)
      option_q <= wr_data;
  end

  // interrupt control; a hardware set wins over a same-cycle clear
  wire [2:0] hw_set = {timer_rollover, ext_edge, pin_change};
  wire [7:0] next_irqctl = wr_irqctl ? (wr_data | {5'h00, hw_set})
                                     : (irqctl_q | {5'h00, hw_set});

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      irqctl_q <= `IRQCTL_RESET;
    else if (ce)
      irqctl_q <= next_irqctl;
  end

  // shared prescaler: owner's source feeds it, other side bypasses
  wire       ps_wdt   = option_q[`OPT_PS_OWNER];
  wire [2:0] ps_rate  = option_q[`OPT_RATE_HI:`OPT_RATE_LO];
  wire       ps_in    = ps_wdt ? wdt_base_tick : tmr_src;
  // timer needs rate+1 low bits saturated, watchdog rate bits
  wire [3:0] ps_bits  = ps_wdt ? {1'b0, ps_rate}
                               : ({1'b0, ps_rate} + 4'h1);
  wire       ps_out   = ps_in && (ps_bits == 4'h0 ||
                        (presc_cnt & low_mask(ps_bits)) ==
                        low_mask(ps_bits));

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      presc_cnt <= 8'h00;
    else if (ce)
    begin
      // owner change restarts the count so no stale partial period leaks
      if (wr_option && (wr_data[`OPT_PS_OWNER] != ps_wdt))
        presc_cnt <= 8'h00;
      else if (ps_in)
        presc_cnt <= presc_cnt + 8'h01;
    end
  end

  // divided or bypassed ticks out, one cycle pulses
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      timer_inc <= 1'b0;
      wdt_tick  <= 1'b0;
    end
    else if (ce)
    begin
      timer_inc <= ps_wdt ? tmr_src : ps_out;
      wdt_tick  <= ps_wdt ? ps_out : wdt_base_tick;
    end
  end

  // pull-ups follow latches unless globally disabled
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      pullup_en <= 6'h00;
    else if (ce)
      pullup_en <= option_q[`OPT_PULLUP_DIS] ? 6'h00 : port_latch;
  end

  // interrupt request; pin-change needs some per-pin enable as well
  wire chg_ok  = irqctl_q[`IC_CHG_IE] && (|per_pin_change_enable);
  wire core_rq = (irqctl_q[`IC_TMR_IE] && irqctl_q[`IC_TMR_IF])
               | (irqctl_q[`IC_EXT_IE] && irqctl_q[`IC_EXT_IF])
               | (chg_ok && irqctl_q[`IC_CHG_IF]);
  wire peri_rq = irqctl_q[`IC_PERIPHERAL_IRQ_GATE] && periph_irq_pending;

  assign irq_request = irqctl_q[`IC_GIE] && (core_rq || peri_rq);

  // read port, registered; unmapped reads return zero with no hit
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rd_data <= 8'h00;
      rd_hit  <= 1'b0;
    end
    else if (ce)
    begin
      rd_hit <= rd_en && (rd_sel != SEL_NONE);
      if (!rd_en)
        rd_data <= 8'h00;
      else
      begin
        case (rd_sel)
          SEL_FLAGS:
            rd_data <= {bank_bits, wdt_exp_flag, sleep_flag, alu_flags};
          SEL_OPTION:
            rd_data <= option_q;
          SEL_IRQCTL:
            rd_data <= irqctl_q;
          default:
            rd_data <= 8'h00;
        endcase
      end
    end
  end

  // the timer count itself lives outside and is not touched by reset

endmodule // core_flags_option_irq_regs

`default_nettype wire

// ===== verification/core_flags_option_irq_regs_checker.sv
`timescale 1ns/100ps
`default_nettype none
module core_flags_option_irq_regs_checker
(
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic       ce,
  input wire logic       wr_en,
  input wire logic [6:0] wr_file_addr,
  input wire logic [7:0] wr_data,
  input wire logic       rd_en,
  input wire logic [6:0] rd_file_addr,
  input wire logic [7:0] rd_data,
  input wire logic       rd_hit,
  input wire logic       alu_valid,
  input wire logic [2:0] alu_op,
  input wire logic [7:0] operand_a,
  input wire logic [7:0] operand_b,
  input wire logic       bank_select_bit,
  input wire logic       carry_flag,
  input wire logic       irq_request
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // helper sum and flags-write decode, shared by several properties
  wire [8:0] sum = {1'b0, operand_a} + {1'b0, operand_b};
  wire       flw = ce && wr_en && wr_file_addr == 7'h03;
  wire       alu = ce && alu_valid;

  property p_bank_decode;
    ce && rd_en && rd_file_addr == 7'h01 |=> rd_hit == $past(bank_select_bit);
  endproperty
  a_bank_decode: assert property (p_bank_decode)
    else $error("option decode ignores bank bit");
  property p_bank_write;
    flw && !alu_valid |=> bank_select_bit == $past(wr_data[5])
      && carry_flag == $past(wr_data[0]);
  endproperty
  a_bank_write: assert property (p_bank_write)
    else $error("flags write lost");
  property p_add_carry;
    alu && alu_op == 3'h0 |=> carry_flag == $past(sum[8]);
  endproperty
  a_add_carry: assert property (p_add_carry)
    else $error("add carry wrong");
  property p_sub_carry;
    alu && alu_op == 3'h1 |=> carry_flag == $past(operand_a >= operand_b);
  endproperty
  a_sub_carry: assert property (p_sub_carry)
    else $error("subtract borrow wrong");
  property p_rotl;
    alu && alu_op == 3'h3 |=> carry_flag == $past(operand_a[7]);
  endproperty
  a_rotl: assert property (p_rotl)
    else $error("rotate left carry wrong");
  property p_rotr;
    alu && alu_op == 3'h4 |=> carry_flag == $past(operand_a[0]);
  endproperty
  a_rotr: assert property (p_rotr)
    else $error("rotate right carry wrong");
  property p_alu_wins;
    flw && alu && alu_op == 3'h0 |=> carry_flag == $past(sum[8])
      && bank_select_bit == $past(wr_data[5]);
  endproperty
  a_alu_wins: assert property (p_alu_wins)
    else $error("write overrode alu flags");
  property p_gie_block;
    rd_hit && $past(rd_file_addr == 7'h0B && !wr_en) && !rd_data[7]
      |-> !irq_request;
  endproperty
  a_gie_block: assert property (p_gie_block)
    else $error("request with global enable clear");
endmodule // core_flags_option_irq_regs_checker

bind core_flags_option_irq_regs core_flags_option_irq_regs_checker i_chk
(
  .clk, .reset_n, .ce, .wr_en, .wr_file_addr, .wr_data, .rd_en,
  .rd_file_addr, .rd_data, .rd_hit, .alu_valid, .alu_op, .operand_a,
  .operand_b, .bank_select_bit, .carry_flag, .irq_request
);
`default_nettype wire

// ===== verification/core_model.sv
`timescale 1ns/100ps
`default_nettype none
module core_model
(
  input  wire logic       clk,
  input  wire logic [7:0] rd_data,
  output var  logic       wr_en,
  output var  logic [6:0] wr_file_addr,
  output var  logic [7:0] wr_data,
  output var  logic       rd_en,
  output var  logic [6:0] rd_file_addr,
  output var  logic       alu_valid,
  output var  logic [2:0] alu_op,
  output var  logic [7:0] operand_a,
  output var  logic [7:0] operand_b
);
  // idle core: no strobes at time zero
  initial
  begin
    {wr_en, rd_en, alu_valid, alu_op} = 6'h00;
    {wr_file_addr, rd_file_addr, wr_data} = 22'h0;
    {operand_a, operand_b} = 16'h0000;
  end
  // one write; data inverted after release so stale values never match
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    wr_en = 1'b1;
    wr_file_addr = a;
    wr_data = (a == 7'h03) ? (d & 8'h3F) : d;
    @(posedge clk);
    #1;
    wr_en = 1'b0;
    wr_data = ~wr_data;
  endtask
  // read data stands just after the edge that takes the read
  task automatic rd(input logic [6:0] a, output logic [7:0] v);
    @(posedge clk);
    #1;
    rd_en = 1'b1;
    rd_file_addr = a;
    @(posedge clk);
    #1;
    rd_en = 1'b0;
    rd_file_addr = ~a;
    v = rd_data;
  endtask
  // one flag-affecting operation
  task automatic alu(input logic [2:0] op, input logic [7:0] a, b);
    @(posedge clk);
    #1;
    {alu_valid, alu_op, operand_a, operand_b} = {1'b1, op, a, b};
    @(posedge clk);
    #1;
    {alu_valid, operand_a, operand_b} = {1'b0, ~a, ~b};
  endtask
endmodule // core_model
`default_nettype wire

// ===== verification/core_flags_option_irq_regs_tb.sv
`timescale 1ns/100ps
`default_nettype none
module core_flags_option_irq_regs_tb;
  logic       clk, reset_n, ce, periph_irq_pending, ext_irq_pin;
  logic       timer_clock_pin, rd_hit, bank_select_bit, carry_flag;
  logic       timer_inc, wdt_tick, irq_request, wr_en, rd_en, alu_valid;
  logic       watchdog_clear_instr, sleep_instr, wdt_timeout;
  logic       instr_clk_tick, wdt_base_tick, timer_rollover;
  logic [2:0] alu_op, op;
  logic [6:0] wr_file_addr, rd_file_addr;
  logic [7:0] wr_data, rd_data, operand_a, operand_b, v, a, b, fl, seed;
  logic [5:0] per_pin_change_enable, port_latch, gpio_pins, pullup_en, ev;
  int         n_fail, cmp_count, cyc, i, nt, nw;
  logic [5:0] evp [5] = '{6'h01, 6'h02, 6'h04, 6'h05, 6'h04};
  logic [7:0] eve [5] = '{8'h28, 8'h30, 8'h38, 8'h28, 8'h38};

  assign {wdt_base_tick, instr_clk_tick, timer_rollover,
          watchdog_clear_instr, sleep_instr, wdt_timeout} = ev;
  core_flags_option_irq_regs i_dut (.clk, .reset_n, .ce, .wr_en,
    .wr_file_addr, .wr_data, .rd_en, .rd_file_addr, .rd_data, .rd_hit,
    .alu_valid, .alu_op, .operand_a, .operand_b, .watchdog_clear_instr,
    .sleep_instr, .wdt_timeout, .instr_clk_tick, .wdt_base_tick,
    .timer_rollover, .periph_irq_pending, .per_pin_change_enable,
    .port_latch, .gpio_pins, .ext_irq_pin, .timer_clock_pin,
    .bank_select_bit, .carry_flag, .pullup_en, .timer_inc, .wdt_tick,
    .irq_request);
  core_model m (.clk, .rd_data, .wr_en, .wr_file_addr, .wr_data, .rd_en,
    .rd_file_addr, .alu_valid, .alu_op, .operand_a, .operand_b);

  task automatic chk(input logic [7:0] got, exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // one-cycle event pulse, launched just after an edge
  task automatic pulse(input logic [5:0] p);
    @(posedge clk);
    #1 ev = p;
    @(posedge clk);
    #1 ev = 6'h00;
  endtask
  function automatic logic [7:0] nxt(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // expected zero, digit carry, carry; subtract adds the complement
  function automatic logic [2:0] zdc(input logic [2:0] o,
    input logic [7:0] x, y, input logic [2:0] old);
    logic [8:0] s;
    logic [4:0] h;
    s = (o == 3'h1) ? {1'b0, x} + {1'b0, ~y} + 9'h001 : {1'b0, x} + y;
    h = (o == 3'h1) ? {1'b0, x[3:0]} + {1'b0, ~y[3:0]} + 5'h01
                    : {1'b0, x[3:0]} + y[3:0];
    case (o)
      3'h2: return {x == 8'h00, old[1:0]};
      3'h3: return {old[2:1], x[7]};
      3'h4: return {old[2:1], x[0]};
      default: return {s[7:0] == 8'h00, h[4], s[8]};
    endcase
  endfunction

  // clock, plus cycle ceiling against hangs; also counts tick pulses
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    nt += int'(timer_inc);
    nw += int'(wdt_tick);
    if (cyc == 8000)
    begin
      n_fail++;
      close_out;
    end
  end

  initial
  begin
    {reset_n, periph_irq_pending, ext_irq_pin, timer_clock_pin} = 4'h0;
    {ev, per_pin_change_enable, port_latch, gpio_pins} = 24'h0;
    ce = 1'b1;
    seed = 8'h5A;
    repeat (10) @(posedge clk);
    #1 reset_n = 1'b1;
    m.rd(7'h03, v);
    chk(v, 8'h18);
    m.wr(7'h03, 8'h20);
    m.rd(7'h03, v);
    chk(v, 8'h38);
    m.rd(7'h01, v);
    chk(v, 8'hFF);
    for (i = 0; i < 5; i++)
    begin
      pulse(evp[i]);
      m.rd(7'h03, v);
      chk(v, eve[i]);
    end
    fl = 8'h38;
    // random operations with hand-picked corners first
    for (i = 0; i < 40; i++)
    begin
      seed = nxt(seed);
      a = seed;
      seed = nxt(seed);
      b = seed;
      op = 3'(seed % 8'h05);
      if (i == 0)
        {op, a, b} = {3'h0, 16'hFF01};
      if (i == 1)
        {op, a, b} = {3'h1, 16'h3C3C};
      m.alu(op, a, b);
      fl[2:0] = zdc(op, a, b, fl[2:0]);
      m.rd(7'h03, v);
      chk(v, fl);
    end
    fork
      m.wr(7'h03, 8'h07);
      m.alu(3'h0, 8'h00, 8'h00);
    join
    m.rd(7'h03, v);
    chk(v, 8'h1C);
    // logic op into flags: carry and digit carry ignore the write too
    fork
      m.wr(7'h03, 8'h03);
      m.alu(3'h2, 8'h00, 8'h00);
    join
    m.rd(7'h03, v);
    chk(v, 8'h1C);
    m.rd(7'h01, v);
    chk({v[6:0], rd_hit}, 8'h00);
    m.wr(7'h03, 8'h20);
    // count clears on owner change; ticks spaced two cycles apart
    for (i = 0; i < 6; i++)
    begin
      m.wr(7'h01, {4'h4, ~i[0], 3'h0});
      m.wr(7'h01, {4'h4, i[0], 1'b0, i[2:1]});
      #1 {nt, nw} = 0;
      repeat (16) pulse(6'h30);
      repeat (3) @(posedge clk);
      #1 chk(8'(nt), i[0] ? 8'h10 : 8'h10 >> (i[2:1] + 1));
      chk(8'(nw), i[0] ? 8'h10 >> i[2:1] : 8'h10);
    end
    // timer from its pin; edge select decides which transition counts
    for (i = 0; i < 4; i++)
    begin
      m.wr(7'h01, {2'h0, 1'b1, i[1], 4'h8});
      {nt, nw} = 0;
      timer_clock_pin = ~timer_clock_pin;
      repeat (8) @(posedge clk);
      #1 chk(8'(nt), {7'h0, i[0] == i[1]});
    end
    port_latch = seed[5:0];
    repeat (3) @(posedge clk);
    #1 chk({2'h0, pullup_en}, {2'h0, seed[5:0]});
    m.wr(7'h01, 8'hCA);
    repeat (3) @(posedge clk);
    #1 chk({2'h0, pullup_en}, 8'h00);
    m.wr(7'h0B, 8'h00);
    pulse(6'h08);
    m.rd(7'h0B, v);
    chk(v, 8'h04);
    m.wr(7'h0B, 8'hA4);
    chk({7'h0, irq_request}, 8'h01);
    m.wr(7'h0B, 8'h24);
    chk({7'h0, irq_request}, 8'h00);
    periph_irq_pending = 1'b1;
    m.wr(7'h0B, 8'h80);
    chk({7'h0, irq_request}, 8'h00);
    m.wr(7'h0B, 8'hC0);
    chk({7'h0, irq_request}, 8'h01);
    periph_irq_pending = 1'b0;
    // external edge: rising sets with bit 6 high, falling with it low
    for (i = 0; i < 2; i++)
    begin
      m.wr(7'h01, {1'b0, ~i[0], 6'h0A});
      m.wr(7'h0B, 8'h00);
      ext_irq_pin = ~ext_irq_pin;
      repeat (8) @(posedge clk);
      m.rd(7'h0B, v);
      chk(v, 8'h02);
    end
    m.wr(7'h0B, 8'h00);
    gpio_pins = 6'h21;
    repeat (8) @(posedge clk);
    m.rd(7'h0B, v);
    chk(v, 8'h01);
    m.wr(7'h0B, 8'h89);
    chk({7'h0, irq_request}, 8'h00);
    per_pin_change_enable = 6'h01;
    #1 chk({7'h0, irq_request}, 8'h01);
    // frozen clock enable: a write in that window must not land
    @(posedge clk);
    #1 ce = 1'b0;
    m.wr(7'h0B, 8'h00);
    ce = 1'b1;
    m.rd(7'h0B, v);
    chk(v, 8'h89);
    close_out;
  end
endmodule // core_flags_option_irq_regs_tb
`default_nettype wire
